/* inc/mode_ctrl_pkg.sv */
// Package of constants and types for the converter mode control register
// What this block does
// - Any write to the mode register clears filter and ready and restarts conversion, all in the cycle after the write.
// - After reset the register reads 0x2000.
// - Bit 15 enables internal reference and drives the reference output pin.
// - Bit 13 restricts output to the settled filter rate; resets to one.
// - Bits 10:8 select post-switch delay 0 us up to 8 ms.
// - Bits 6:4 select operating mode, continuous through system gain calibration.
// - Bits 3:2 select clock source: internal, internal out, external, crystal.
// - Either internal oscillator code powers up the internal oscillator.
package mode_ctrl_pkg;
   localparam logic [7:0]  MODE_CTRL_ADDR  = 8'h01;
   localparam logic [15:0] MODE_CTRL_RESET = 16'h2000;
   localparam logic [15:0] MODE_CTRL_WMASK = 16'hA77C;
   localparam int          REF_EN_BIT      = 15;
   localparam int          RSVD14_BIT      = 14;
   localparam int          SETTLED_BIT     = 13;
   localparam int          DELAY_LSB       = 8;
   localparam int          MODE_LSB        = 4;
   localparam int          CLKSEL_LSB      = 2;
   localparam int          CLOCK_MHZ       = 250;
   // Delay figures in microseconds, index is the delay code
   localparam int          DELAY_US [8]    = '{0, 32, 128, 320, 800, 1600, 4000, 8000};

   typedef enum logic [2:0] {
      MODE_CONTINUOUS, MODE_SINGLE, MODE_STANDBY, MODE_POWER_DOWN,
      MODE_INT_OFFSET_CAL, MODE_INT_GAIN_CAL, MODE_SYS_OFFSET_CAL, MODE_SYS_GAIN_CAL
   } op_mode_t;

   typedef enum logic [1:0] {
      CLK_INT_OSC, CLK_INT_OSC_OUT, CLK_EXT_CLOCK, CLK_EXT_CRYSTAL
   } clk_src_t;

   // Cycle count for a delay code at the block clock rate
   function automatic logic [21:0] delay_cycles(input logic [2:0] code);
      delay_cycles = 22'(DELAY_US[code] * CLOCK_MHZ);
   endfunction
endpackage

/* src/settle_delay.sv */
// Post channel switch settling delay counter
`timescale 1ns/10ps
module settle_delay
   import mode_ctrl_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic       start_i,
   input  wire logic [2:0] code_i,
   output logic            busy_o
);
   logic [21:0] count_q;
   wire  [21:0] load_w = delay_cycles(code_i);

   assign busy_o = (count_q != 22'h00_0000);

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         count_q <= 22'h00_0000;
      end else if (start_i) begin
         count_q <= load_w;
      end else if (busy_o) begin
         count_q <= count_q - 22'h00_0001;
      end
   end

   settle_load_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      start_i && code_i == 3'h1
      |=> count_q == 22'(DELAY_US[1] * CLOCK_MHZ))
      else $error("settle count not loaded for the 32 us code");
endmodule

/* src/mode_ctrl.sv */
// Converter mode control register with restart and control outputs
`timescale 1ns/10ps
module mode_ctrl
   import mode_ctrl_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_write_i,
   input  wire logic        channel_switch_i,
   output logic [15:0]      mode_rdata_o,
   output logic             filter_reset_o,
   output logic             ready_clear_o,
   output logic             conv_start_o,
   output logic             ref_enable_o,
   output logic             settled_only_output_o,
   output logic             settle_busy_o,
   output op_mode_t         op_mode_o,
   output clk_src_t         clock_source_select_o,
   output logic             int_osc_enable_o,
   output logic             clock_io_out_en_o,
   output logic             crystal_enable_o
);
   logic [15:0] mode_q;
   logic        restart_q;

   wire         hit_w   = reg_write_i && (reg_addr_i == MODE_CTRL_ADDR);
   // Only writable bits are stored; reserved positions stay zero
   wire  [15:0] mode_d  = reg_wdata_i & MODE_CTRL_WMASK;
   wire  [1:0]  clk_w   = mode_q[CLKSEL_LSB +: 2];

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         mode_q <= MODE_CTRL_RESET;
      end else if (hit_w) begin
         mode_q <= mode_d;
      end
   end

   // Restart pulse one cycle after the write so it sees the new mode
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         restart_q <= 1'b0;
      end else begin
         restart_q <= hit_w;
      end
   end

   assign mode_rdata_o          = mode_q;
   assign filter_reset_o        = restart_q;
   assign ready_clear_o         = restart_q;
   assign conv_start_o          = restart_q;
   assign ref_enable_o          = mode_q[REF_EN_BIT];
   assign settled_only_output_o = mode_q[SETTLED_BIT];
   assign op_mode_o             = op_mode_t'(mode_q[MODE_LSB +: 3]);
   assign clock_source_select_o = clk_src_t'(clk_w);
   // Both internal oscillator codes have the upper select bit clear
   assign int_osc_enable_o      = !clk_w[1];
   assign clock_io_out_en_o     = (clk_w == CLK_INT_OSC_OUT);
   assign crystal_enable_o      = (clk_w == CLK_EXT_CRYSTAL);

   // A switch or a restart both start the settling wait
   settle_delay u_settle (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .start_i (channel_switch_i | restart_q),
      .code_i  (mode_q[DELAY_LSB +: 3]),
      .busy_o  (settle_busy_o)
   );

   // Named steps of a register access, shared by the checks below
   sequence write_s;
      hit_w;
   endsequence

   sequence single_write_s;
      write_s ##1 !hit_w;
   endsequence

   sequence stray_write_s;
      reg_write_i && (reg_addr_i != MODE_CTRL_ADDR);
   endsequence

   sequence restart_s;
      filter_reset_o && ready_clear_o && conv_start_o;
   endsequence

   // A wait only starts when the stored code asks for one
   sequence settle_start_s;
      (channel_switch_i || conv_start_o) && (mode_rdata_o[DELAY_LSB +: 3] != 3'h0);
   endsequence

   sequence settle_skip_s;
      (channel_switch_i || conv_start_o) && (mode_rdata_o[DELAY_LSB +: 3] == 3'h0);
   endsequence

   restart_after_write_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      write_s
      |=> restart_s)
      else $error("write did not restart conversion");

   // Every restart must trace back to a write on this address
   restart_cause_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      conv_start_o
      |-> $past(hit_w))
      else $error("restart without a write");

   restart_single_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      single_write_s
      |=> !conv_start_o && !filter_reset_o && !ready_clear_o)
      else $error("restart pulse longer than one cycle");

   stray_write_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      stray_write_s
      |=> !conv_start_o && $stable(mode_rdata_o))
      else $error("write to another address touched the mode register");

   quiet_bus_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      !reg_write_i
      |=> !conv_start_o)
      else $error("restart while the bus was idle");

   // Reset checks run without disable so the reset cycles themselves are watched
   reset_value_a: assert property (
      @(posedge clock_i)
      rst_i
      |=> (mode_rdata_o == MODE_CTRL_RESET) && !conv_start_o && !settle_busy_o)
      else $error("mode register reset value wrong");

   reset_fields_a: assert property (
      @(posedge clock_i)
      rst_i
      |=> settled_only_output_o && !ref_enable_o && (op_mode_o == MODE_CONTINUOUS))
      else $error("mode fields wrong after reset");

   ref_enable_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      write_s
      |=> ref_enable_o == $past(reg_wdata_i[15]))
      else $error("reference enable not taken");

   ref_hold_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      !reg_write_i
      |=> $stable(ref_enable_o))
      else $error("reference enable changed without a write");

   settled_only_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      write_s
      |=> settled_only_output_o == $past(reg_wdata_i[13]))
      else $error("settled only bit not taken");

   delay_field_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      write_s
      |=> mode_rdata_o[DELAY_LSB +: 3] == $past(reg_wdata_i[DELAY_LSB +: 3]))
      else $error("delay field not taken");

   settle_start_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      settle_start_s
      |=> settle_busy_o)
      else $error("settling wait did not start");

   settle_skip_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      settle_skip_s
      |=> !settle_busy_o)
      else $error("settling wait started for the zero code");

   op_mode_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      write_s
      |=> op_mode_o == op_mode_t'($past(reg_wdata_i[6:4])))
      else $error("mode field not taken");

   clk_select_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      write_s
      |=> clock_source_select_o == clk_src_t'($past(reg_wdata_i[3:2])))
      else $error("clock source field not taken");

   clk_pins_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      write_s
      |=> clock_io_out_en_o == ($past(reg_wdata_i[3:2]) == 2'h1))
      else $error("clock pin drive mismatch");

   crystal_pins_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      write_s
      |=> crystal_enable_o == ($past(reg_wdata_i[3:2]) == 2'h3))
      else $error("crystal enable mismatch");

   // The crystal needs both pins, so nothing else may use the clock pin then
   clk_exclusive_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      !(crystal_enable_o && (int_osc_enable_o || clock_io_out_en_o)))
      else $error("crystal and oscillator enabled together");

   int_osc_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      int_osc_enable_o == (clock_source_select_o inside {CLK_INT_OSC, CLK_INT_OSC_OUT}))
      else $error("oscillator enable mismatch");

   // Reserved bits are dropped on the way in, so a stray one from the host reads zero
   reserved_zero_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (mode_rdata_o & ~MODE_CTRL_WMASK) == 16'h0000)
      else $error("reserved bits not zero");

   reserved_ignore_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      write_s
      |=> mode_rdata_o == ($past(reg_wdata_i) & MODE_CTRL_WMASK))
      else $error("written value not stored with reserved bits cleared");
endmodule

/* verif/host_model.sv */
// Host model that writes the mode control register
`timescale 1ns/10ps
module host_model (
   input  wire logic   clock_i,
   output logic [7:0]  reg_addr_o,
   output logic [15:0] reg_wdata_o,
   output logic        reg_write_o
);
   initial begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 16'h0000;
      reg_write_o = 1'b0;
   end
   // Raw set only where a scenario means to break the reserved-zero habit
   task automatic write(input logic [7:0] addr, input logic [15:0] data, input bit raw);
      @(negedge clock_i);
      reg_addr_o <= addr;
      reg_wdata_o <= raw ? data : (data & 16'hA77C);
      reg_write_o <= 1'b1;
      @(negedge clock_i);
      reg_write_o <= 1'b0;
      // Released lines stop showing the last value
      reg_addr_o <= ~addr;
      reg_wdata_o <= ~data;
   endtask
endmodule

/* verif/tb_mode_ctrl.sv */
// Testbench for the mode control register
`timescale 1ns/10ps
module tb_mode_ctrl;
   import mode_ctrl_pkg::*;
   logic        clock_i  = 1'b0;
   logic        rst_i    = 1'b1;
   logic        sw       = 1'b0;
   logic [7:0]  addr;
   logic [15:0] wdata, rdata;
   logic        wr, frst, rclr, cst, ref_en, settled, busy, int_osc, io_en, xtal;
   op_mode_t    mode;
   clk_src_t    clk;
   int          failures = 0;
   int          n_tests  = 0;
   always #2 clock_i = ~clock_i;
   host_model u_host (.clock_i(clock_i), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_write_o(wr));
   mode_ctrl u_dut (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_write_i(wr), .channel_switch_i(sw), .mode_rdata_o(rdata), .filter_reset_o(frst),
      .ready_clear_o(rclr), .conv_start_o(cst), .ref_enable_o(ref_en),
      .settled_only_output_o(settled), .settle_busy_o(busy), .op_mode_o(mode),
      .clock_source_select_o(clk), .int_osc_enable_o(int_osc), .clock_io_out_en_o(io_en),
      .crystal_enable_o(xtal));
   task automatic give_verdict;
      $display("failures %0d n_tests %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic t_reset;
      chk(rdata, 16'h2000);
      chk(16'({ref_en, settled, int_osc, io_en, xtal, mode, clk}), 16'h0180);
   endtask
   task automatic t_modes;
      logic [15:0] d;
      for (int i = 0; i < 8; i++) begin
         d = 16'h8000 | 16'(i << 4) | 16'((i % 4) << 2);
         u_host.write(8'h01, d, 1'b0);
         chk(rdata, d);
         chk(16'({frst, rclr, cst, ref_en, mode, clk}), 16'({4'hF, 3'(i), 2'(i % 4)}));
         chk(16'({int_osc, io_en, xtal}), 16'({i % 4 < 2, i % 4 == 1, i % 4 == 3}));
      end
      u_host.write(8'h02, 16'h0000, 1'b0);
      chk(16'({rdata, frst, cst}), 16'({d[13:0], 2'b00}));
   endtask
   task automatic t_reserved;
      u_host.write(8'h01, 16'hFFFF, 1'b1);
      chk(rdata, 16'hA77C);
   endtask
   // Counts busy cycles from the current falling edge on
   task automatic busy_len(output int n);
      n = 0;
      while (busy === 1'b1 && n < 9000) begin
         @(negedge clock_i);
         n++;
      end
      if (n >= 9000) begin
         failures++;
         $display("ERROR %0t got %h exp %h", $time, n, 9000);
      end
   endtask
   task automatic t_delay;
      int n;
      u_host.write(8'h01, 16'h0100, 1'b0);
      // The restart reloads the wait one cycle after the write
      @(negedge clock_i);
      busy_len(n);
      chk(16'(n), 16'(DELAY_US[1] * CLOCK_MHZ));
      sw <= 1'b1;
      @(negedge clock_i);
      sw <= 1'b0;
      busy_len(n);
      // Code 1 is 32 us at the block clock rate
      chk(16'(n), 16'(DELAY_US[1] * CLOCK_MHZ));
   endtask
   task automatic t_rerst;
      u_host.write(8'h01, 16'h0770, 1'b0);
      @(negedge clock_i);
      chk(16'(busy), 16'h0001);
      rst_i = 1'b1;
      repeat (2) @(negedge clock_i);
      rst_i = 1'b0;
      chk(rdata, MODE_CTRL_RESET);
      chk(16'({busy, frst, cst, int_osc}), 16'h0001);
   endtask
   initial begin
      repeat (6) @(posedge clock_i);
      @(negedge clock_i);
      rst_i = 1'b0;
      t_reset;
      t_modes;
      t_reserved;
      t_delay;
      t_rerst;
      give_verdict;
   end
endmodule
